// File: hdl/cpc_pkg.sv
// Purpose: shared constants and types for the compressor protection block
// Assumes: currents in 0.1 A steps, temperatures in whole degrees C, pressure in mV
// Notes: all times are seconds, counted on a one-second tick
package cpc_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TICK_S = 1;
  // register byte offsets and control bits
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_HIST = 4'h8;
  localparam int CTL_RUN = 0;
  localparam int CTL_HEAT = 1;
  localparam int CTL_CLR = 2;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // current limits, 0.1 A units
  localparam logic [9:0] X_HEAT = 10'h0d2;
  localparam logic [9:0] X_COOL = 10'h08a;
  localparam logic [9:0] Y_STOP = 10'h117;
  localparam logic [9:0] PEAK_MAX = 10'h154;
  // temperatures and pressure rail
  localparam logic signed [7:0] SHELL_MAX_C = 8'sh6b;
  localparam logic signed [7:0] AIR_HTR_ON_C = 8'sh05;
  localparam logic signed [7:0] DIS_HTR_ON_C = 8'sh0b;
  localparam logic signed [7:0] AIR_HTR_OFF_C = AIR_HTR_ON_C + 8'sh02;
  localparam logic signed [7:0] DIS_HTR_OFF_C = DIS_HTR_ON_C + 8'sh05;
  localparam logic signed [7:0] AIR_LIM_C = 8'sh0e;
  localparam logic signed [7:0] FRZ_ON_C = 8'sh00;
  localparam logic signed [7:0] FRZ_OFF_C = 8'sh01;
  localparam logic [12:0] PRESS_RAIL_MV = 13'h1388;
  // times in seconds and event counts
  localparam logic [15:0] STOP_DELAY_S = 16'h00b4;
  localparam logic [15:0] PEAK_SLOW_S = 16'h0078;
  localparam logic [15:0] PEAK_QUICK_S = 16'h003c;
  localparam logic [15:0] QUICK_WIN_S = 16'h001e;
  localparam logic [15:0] MIN_RUN_S = 16'h001e;
  localparam logic [15:0] ARM_S = 16'h003c;
  localparam logic [3:0] PRESS_HOLD_S = 4'h5;
  localparam logic [3:0] FRZ_HOLD_S = 4'ha;
  localparam logic [31:0] OC_WIN_S = 32'h0000_04b0;
  localparam logic [31:0] HEAT_WIN_S = 32'h0000_0708;
  localparam logic [31:0] PRESS_WIN_S = 32'h0000_1c20;
  localparam logic [1:0] OC_NEED = 2'h3;
  localparam logic [2:0] HEAT_NEED = 3'h4;
  localparam logic [2:0] PEAK_SEQ = 3'h7;
  typedef enum logic [2:0] {
    LC_NONE, LC_RUN_OVERCURRENT, LC_PEAK_CURRENT, LC_OVERHEAT, LC_PRESSURE_SENSOR,
    LC_COIL_FREEZE
  } cpc_code_t;
  typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_FREEZE, ST_LOCK} cpc_state_t;
  typedef struct packed {
    logic [9:0] runCur;
    logic [9:0] peakCur;
    logic signed [7:0] shellT;
    logic [12:0] pressMv;
    logic signed [7:0] airT;
    logic signed [7:0] disT;
    logic signed [7:0] pipeT;
    logic signed [7:0] hexT;
  } cpc_sense_t;
  typedef struct packed {
    logic compRun;
    logic freqReduce;
    logic curLimit;
    logic coolRegEn;
    logic heaterOn;
    logic deiceOn;
    logic fanStop;
    logic lampBlink;
    cpc_code_t lockCode;
  } cpc_drive_t;
endpackage

// File: hdl/cpc_protect_top.sv
// Purpose: compressor protection supervisor with an AXI4-Lite register port
// Assumes: sensor inputs are synchronous to clk and already scaled
// Notes: protection trips stop at once; only a normal stop waits for the minimum run
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - reduce frequency above mode current threshold
// - restore frequency once current drops back
// - stop compressor above upper current
// - three upper trips in window lock out
// - peak module current stops, three-minute wait
// - slow peak recurrence waits two minutes
// - quick peak recurrence waits one minute
// - seven quick peak trips lock out
// - shell overheat stops; four trips lock
// - pressure checked after one minute running
// - pressure rail or zero five seconds
// - four pressure faults in window lock
// - heater on when air, discharge low
// - heater off beyond hysteresis margins
// - heating limits current above air level
// - deice with fan stopped when cold
// - cooling air regulation after one minute
// - cooling coil below freezing ten seconds stops
// - restart three minutes after coil warms
// - freeze events recorded unless a lockout comes in the same cycle, never lock out
// - three-minute start block after stop
// - minimum thirty seconds run after start
module cpc_protect_top import cpc_pkg::*; #(
  parameter int unsigned TICK_CYCLES = CLK_HZ * TICK_S,
  parameter logic signed [7:0] DEICE_PIPE_C = 8'sh00,
  parameter logic signed [7:0] DEICE_AIR_C = 8'sh00
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [3:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire cpc_sense_t sense,
  input wire logic panelStop,
  output var cpc_drive_t drive
);
  if (TICK_CYCLES < 2) begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  // true when a sliding window already holds need-1 events younger than win
  function automatic logic winHit(input logic [31:0] now, input logic [31:0] old,
                                  input logic [1:0] cnt, input logic [1:0] needM1,
                                  input logic [31:0] win);
    winHit = (cnt >= needM1) && ((now - old) < win);
  endfunction

  // register select from an aligned byte address
  function automatic logic [1:0] regSel(input logic [3:0] a);
    logic [3:0] al;
    al = {a[3:2], 2'b00};
    if (al == OFS_CTRL) regSel = 2'd1;
    else if (al == OFS_STAT) regSel = 2'd2;
    else if (al == OFS_HIST) regSel = 2'd3;
    else regSel = 2'd0;
  endfunction

  logic [31:0] tickCnt_r;
  logic tick;
  logic [31:0] secNow_r;
  cpc_state_t st_r;
  logic [1:0] ctrl_r;
  logic [15:0] delay_r;
  logic [15:0] runSec_r;
  logic [3:0] prSec_r;
  logic [3:0] frSec_r;
  logic pkPrev_r;
  logic [2:0] pkSeq_r;
  logic [31:0] ts_r [3][3];
  logic [1:0] tsCnt_r [3];
  logic [7:0] frzCnt_r;
  cpc_code_t lockCode_r;
  logic freqReduce_r, curLimit_r, coolRegEn_r, heater_r, deice_r, blink_r;
  logic awHave_r, wHave_r, wStrb0_r;
  logic [3:0] awAddr_r;
  logic [31:0] wData_r;
  logic bvalid_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;

  // one-second time base; a long prescale keeps the second timers narrow
  always_ff @(posedge clk) begin
    if (!rst_n) tickCnt_r <= 32'h0;
    else if (tick) tickCnt_r <= 32'h0;
    else tickCnt_r <= tickCnt_r + 32'h1;
  end
  assign tick = (tickCnt_r == TICK_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (!rst_n) secNow_r <= 32'h0;
    else if (tick) secNow_r <= secNow_r + 32'h1;
  end

  // bus side decode
  logic doWr, clrReq, heatMode, runReq, compOn;
  logic [1:0] wSel;
  assign doWr = awHave_r && wHave_r && !bvalid_r;
  assign wSel = regSel(awAddr_r);
  assign clrReq = doWr && wSel == 2'd1 && wStrb0_r && wData_r[CTL_CLR];
  assign heatMode = ctrl_r[CTL_HEAT];
  assign runReq = ctrl_r[CTL_RUN];
  assign compOn = (st_r == ST_RUN);

  // trip conditions, all gated by the compressor running
  logic ocTrip, pkTrip, htTrip, prTrip, frTrip, anyTrip, prBad, quick;
  logic normStop, startOk;
  assign ocTrip = compOn && sense.runCur > Y_STOP;
  assign pkTrip = compOn && sense.peakCur > PEAK_MAX;
  assign htTrip = compOn && sense.shellT > SHELL_MAX_C;
  assign prBad = sense.pressMv >= PRESS_RAIL_MV || sense.pressMv == 13'h0;
  assign prTrip = compOn && prSec_r >= PRESS_HOLD_S;
  assign frTrip = compOn && !heatMode && frSec_r >= FRZ_HOLD_S;
  assign anyTrip = ocTrip || pkTrip || htTrip || prTrip || frTrip;
  assign quick = pkPrev_r && runSec_r < QUICK_WIN_S;
  // minimum run honoured; panel stop overrides it
  assign normStop = compOn && ((!runReq && runSec_r >= MIN_RUN_S) || panelStop);
  // start only once the stop delay has run out
  assign startOk = st_r == ST_OFF && runReq && !panelStop && delay_r == 16'h0;

  // lockout decision; window hits use history before this event is stored
  logic [2:0] evt;
  logic ocLock, pkLock, htLock, prLock;
  cpc_code_t lockNxt;
  assign evt = {prTrip, htTrip, ocTrip};
  assign ocLock = ocTrip && winHit(secNow_r, ts_r[0][1], tsCnt_r[0], OC_NEED - 2'h1, OC_WIN_S);
  assign pkLock = pkTrip && quick && pkSeq_r == PEAK_SEQ - 3'h1;
  assign htLock = htTrip && winHit(secNow_r, ts_r[1][2], tsCnt_r[1],
                                   2'(HEAT_NEED - 3'h1), HEAT_WIN_S);
  assign prLock = prTrip && winHit(secNow_r, ts_r[2][2], tsCnt_r[2],
                                   2'(HEAT_NEED - 3'h1), PRESS_WIN_S);
  always_comb begin
    if (ocLock) lockNxt = LC_RUN_OVERCURRENT;
    else if (pkLock) lockNxt = LC_PEAK_CURRENT;
    else if (htLock) lockNxt = LC_OVERHEAT;
    else if (prLock) lockNxt = LC_PRESSURE_SENSOR;
    else lockNxt = LC_NONE;
  end

  // compressor state machine
  always_ff @(posedge clk) begin
    if (!rst_n) st_r <= ST_OFF;
    else begin
      case (st_r)
        ST_OFF: if (startOk) st_r <= ST_RUN;
        ST_RUN: begin
          if (lockNxt != LC_NONE) st_r <= ST_LOCK;
          else if (frTrip) st_r <= ST_FREEZE;
          else if (anyTrip || normStop) st_r <= ST_OFF;
        end
        // wait for the coil to warm
        ST_FREEZE: if (sense.hexT > FRZ_OFF_C) st_r <= ST_OFF;
        ST_LOCK: if (clrReq) st_r <= ST_OFF;
        default: st_r <= ST_OFF;
      endcase
    end
  end

  // restart delay; a peak recurrence shortens it, other stops use the full wait
  always_ff @(posedge clk) begin
    if (!rst_n) delay_r <= 16'h0;
    else if (compOn && pkTrip) begin
      if (!pkPrev_r) delay_r <= STOP_DELAY_S;
      else if (quick) delay_r <= PEAK_QUICK_S;
      else delay_r <= PEAK_SLOW_S;
    end else if ((compOn && (anyTrip || normStop)) ||
                 (st_r == ST_FREEZE && sense.hexT > FRZ_OFF_C)) begin
      delay_r <= STOP_DELAY_S;
    end else if (tick && delay_r != 16'h0 && st_r == ST_OFF) delay_r <= delay_r - 16'h1;
  end

  // seconds since start, saturating
  always_ff @(posedge clk) begin
    if (!rst_n) runSec_r <= 16'h0;
    else if (startOk) runSec_r <= 16'h0;
    else if (compOn && tick && runSec_r != 16'hffff) runSec_r <= runSec_r + 16'h1;
  end

  // continuous-fault second counters
  always_ff @(posedge clk) begin
    if (!rst_n) prSec_r <= 4'h0;
    else if (!compOn || runSec_r < ARM_S || !prBad) prSec_r <= 4'h0;
    else if (tick && prSec_r < PRESS_HOLD_S) prSec_r <= prSec_r + 4'h1;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) frSec_r <= 4'h0;
    else if (!compOn || heatMode || sense.hexT >= FRZ_ON_C) frSec_r <= 4'h0;
    else if (tick && frSec_r < FRZ_HOLD_S) frSec_r <= frSec_r + 4'h1;
  end

  // peak recurrence tracking; any other stop breaks the chain
  always_ff @(posedge clk) begin
    if (!rst_n || clrReq) begin
      pkPrev_r <= 1'b0;
      pkSeq_r <= 3'h0;
    end else if (pkTrip) begin
      pkPrev_r <= 1'b1;
      pkSeq_r <= quick ? pkSeq_r + 3'h1 : 3'h0;
    end else if (compOn && (anyTrip || normStop)) begin
      pkPrev_r <= 1'b0;
      pkSeq_r <= 3'h0;
    end
  end

  // trip time stamps per window, newest first
  always_ff @(posedge clk) begin
    if (!rst_n || clrReq) begin
      for (int k = 0; k < 3; k++) begin
        tsCnt_r[k] <= 2'h0;
        for (int j = 0; j < 3; j++) ts_r[k][j] <= 32'h0;
      end
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (evt[k]) begin
          ts_r[k][0] <= secNow_r;
          ts_r[k][1] <= ts_r[k][0];
          ts_r[k][2] <= ts_r[k][1];
          if (tsCnt_r[k] != 2'h3) tsCnt_r[k] <= tsCnt_r[k] + 2'h1;
        end
      end
    end
  end

  // lockout code held until a clear request; a new lockout beats a clear in the same
  // cycle, so the code always agrees with the lock state
  always_ff @(posedge clk) begin
    if (!rst_n) lockCode_r <= LC_NONE;
    else if (compOn && lockNxt != LC_NONE) lockCode_r <= lockNxt;
    else if (clrReq) lockCode_r <= LC_NONE;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) frzCnt_r <= 8'h0;
    else if (compOn && frTrip && lockNxt == LC_NONE && frzCnt_r != 8'hff)
      frzCnt_r <= frzCnt_r + 8'h1;
  end

  // panel lamp blinks at half the tick rate while locked
  always_ff @(posedge clk) begin
    if (!rst_n || st_r != ST_LOCK) blink_r <= 1'b0;
    else if (tick) blink_r <= !blink_r;
  end

  // frequency and current regulation outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      freqReduce_r <= 1'b0;
      curLimit_r <= 1'b0;
      coolRegEn_r <= 1'b0;
    end else begin
      freqReduce_r <= compOn && sense.runCur > (heatMode ? X_HEAT : X_COOL);
      curLimit_r <= heatMode && sense.airT > AIR_LIM_C;
      coolRegEn_r <= compOn && !heatMode && runSec_r >= ARM_S;
    end
  end

  // crankcase heater with hysteresis; off wins if both hold
  always_ff @(posedge clk) begin
    if (!rst_n) heater_r <= 1'b0;
    else if (sense.airT > AIR_HTR_OFF_C || sense.disT > DIS_HTR_OFF_C) heater_r <= 1'b0;
    else if (sense.airT < AIR_HTR_ON_C && sense.disT <= DIS_HTR_ON_C) heater_r <= 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) deice_r <= 1'b0;
    else deice_r <= compOn && heatMode && sense.pipeT < DEICE_PIPE_C &&
                    sense.airT < DEICE_AIR_C;
  end

  always_comb begin
    drive.compRun = compOn;
    drive.freqReduce = freqReduce_r;
    drive.curLimit = curLimit_r;
    drive.coolRegEn = coolRegEn_r;
    drive.heaterOn = heater_r;
    drive.deiceOn = deice_r;
    drive.fanStop = deice_r;
    drive.lampBlink = blink_r;
    drive.lockCode = lockCode_r;
  end

  // write address and data may arrive in either order
  assign s_axi_awready = !awHave_r && !bvalid_r;
  assign s_axi_wready = !wHave_r && !bvalid_r;
  always_ff @(posedge clk) begin
    if (!rst_n || doWr) awHave_r <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready) awHave_r <= 1'b1;
    if (!rst_n || doWr) wHave_r <= 1'b0;
    else if (s_axi_wvalid && s_axi_wready) wHave_r <= 1'b1;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awAddr_r <= 4'h0;
      wData_r <= 32'h0;
      wStrb0_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) awAddr_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r <= s_axi_wdata;
        wStrb0_r <= s_axi_wstrb[0];
      end
    end
  end

  // control register; only byte lane 0 carries bits
  always_ff @(posedge clk) begin
    if (!rst_n) ctrl_r <= CTRL_RST;
    else if (doWr && wSel == 2'd1 && wStrb0_r) ctrl_r <= wData_r[1:0];
  end

  // write response; unmapped addresses answer with an error
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (doWr) begin
      bvalid_r <= 1'b1;
      bresp_r <= (wSel == 2'd0) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) bvalid_r <= 1'b0;
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // read channel, one outstanding read
  logic [1:0] rSel;
  assign rSel = regSel(s_axi_araddr);
  assign s_axi_arready = !rvalid_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rresp_r <= (rSel == 2'd0) ? RESP_SLVERR : RESP_OKAY;
      case (rSel)
        2'd1: rdata_r <= {30'h0, ctrl_r};
        2'd2: rdata_r <= {18'h0, st_r, 1'b0, lockCode_r, blink_r, deice_r, deice_r,
                          heater_r, coolRegEn_r, curLimit_r, freqReduce_r, compOn};
        2'd3: rdata_r <= {13'h0, pkSeq_r, 5'h0,
                          (frzCnt_r != 8'h0) ? LC_COIL_FREEZE : LC_NONE, frzCnt_r};
        default: rdata_r <= 32'h0;
      endcase
    end else if (s_axi_rready) rvalid_r <= 1'b0;
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // checks on the protection behaviour
  sequence s_started;
    $rose(compOn);
  endsequence
  sequence s_shortRun;
    compOn && runSec_r < MIN_RUN_S && !panelStop && !anyTrip && runReq;
  endsequence

  property p_reduce;
    @(posedge clk) disable iff (!rst_n)
      compOn && sense.runCur > (heatMode ? X_HEAT : X_COOL) |=> freqReduce_r;
  endproperty
  a_reduce: assert property (p_reduce) else $error("no reduction above threshold");
  property p_restore;
    @(posedge clk) disable iff (!rst_n)
      compOn && sense.runCur <= (heatMode ? X_HEAT : X_COOL) |=> !freqReduce_r;
  endproperty
  a_restore: assert property (p_restore) else $error("reduction kept below threshold");
  property p_ocStop;
    @(posedge clk) disable iff (!rst_n) ocTrip |=> !compOn;
  endproperty
  a_ocStop: assert property (p_ocStop) else $error("no stop above upper current");
  property p_quickWait;
    @(posedge clk) disable iff (!rst_n)
      pkTrip && quick && !pkLock |=> delay_r == PEAK_QUICK_S && st_r == ST_OFF;
  endproperty
  a_quickWait: assert property (p_quickWait) else $error("quick recurrence wait wrong");
  property p_stopBlock;
    @(posedge clk) disable iff (!rst_n) $fell(compOn) && st_r == ST_OFF |-> delay_r != 16'h0;
  endproperty
  a_stopBlock: assert property (p_stopBlock) else $error("stop without restart delay");
  property p_minRun;
    @(posedge clk) disable iff (!rst_n) s_started ##0 s_shortRun |=> compOn;
  endproperty
  a_minRun: assert property (p_minRun) else $error("compressor left early after start");
  property p_heatOn;
    @(posedge clk) disable iff (!rst_n)
      sense.airT < AIR_HTR_ON_C && sense.disT <= DIS_HTR_ON_C ##1 $stable(sense) |-> heater_r;
  endproperty
  a_heatOn: assert property (p_heatOn) else $error("heater not on when cold");
  property p_heatOff;
    @(posedge clk) disable iff (!rst_n)
      sense.airT > AIR_HTR_OFF_C || sense.disT > DIS_HTR_OFF_C |=> !heater_r;
  endproperty
  a_heatOff: assert property (p_heatOff) else $error("heater kept on past margin");
  property p_lockHold;
    @(posedge clk) disable iff (!rst_n)
      st_r == ST_LOCK && !clrReq |=> st_r == ST_LOCK && $stable(lockCode_r);
  endproperty
  a_lockHold: assert property (p_lockHold) else $error("lockout released without clear");
  property p_pressArm;
    @(posedge clk) disable iff (!rst_n) runSec_r < ARM_S |-> prSec_r == 4'h0;
  endproperty
  a_pressArm: assert property (p_pressArm) else $error("pressure watched before arming");
endmodule
`default_nettype wire

// File: verification/cpc_plant_model.sv
// Purpose: far-side plant model feeding the sensor bus
// Assumes: the bench sets the wanted readings
// Notes: motor currents read zero while the compressor idles
`timescale 1ns/1ps
`default_nettype none
module cpc_plant_model import cpc_pkg::*; (
  input wire logic clk,
  input wire logic compRun,
  input wire cpc_sense_t want,
  output var cpc_sense_t sense
);
  // idle motor draws nothing, so a fault current comes back only on restart
  always_ff @(posedge clk) begin
    sense <= want;
    if (!compRun) begin
      sense.runCur <= 10'h000;
      sense.peakCur <= 10'h000;
    end
  end
endmodule
`default_nettype wire

// File: verification/cpc_protect_test.sv
// Purpose: self-checking bench for the protection block
// Assumes: one second is shortened to T clocks
// Notes: each lockout runs to completion through real restarts
`timescale 1ns/1ps
`default_nettype none
module cpc_protect_test import cpc_pkg::*;;
  localparam int T = 4;
  logic clk = 1'h0, rst_n = 1'h0, awV = 1'h0, wV = 1'h0, bR = 1'h1;
  logic arV = 1'h0, rR = 1'h1, panelStop = 1'h0, heat;
  logic awR, wR, bV, arR, rV;
  logic [3:0] awA = 4'h0, arA = 4'h0;
  logic [31:0] wD = 32'h0, rD, rdv;
  logic [1:0] bRsp, rRsp, rsp;
  cpc_sense_t want, sense;
  cpc_drive_t drive;
  cpc_code_t codes [4] = '{LC_RUN_OVERCURRENT, LC_PEAK_CURRENT, LC_OVERHEAT,
                           LC_PRESSURE_SENSOR};
  int err_total = 0, checks = 0, g0, g1;
  // free-running system clock
  initial begin
    forever #4 clk = ~clk;
  end
  cpc_protect_top #(.TICK_CYCLES(T)) u_cpc_protect_top (.clk(clk), .rst_n(rst_n),
    .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_awaddr(awA), .s_axi_wvalid(wV),
    .s_axi_wready(wR), .s_axi_wdata(wD), .s_axi_wstrb(4'hf), .s_axi_bvalid(bV),
    .s_axi_bready(bR), .s_axi_bresp(bRsp), .s_axi_arvalid(arV), .s_axi_arready(arR),
    .s_axi_araddr(arA), .s_axi_rvalid(rV), .s_axi_rready(rR), .s_axi_rdata(rD),
    .s_axi_rresp(rRsp), .sense(sense), .panelStop(panelStop), .drive(drive));
  cpc_plant_model u_cpc_plant_model (.clk(clk), .compRun(drive.compRun), .want(want),
    .sense(sense));
  // comparison and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("errors=%0d checks=%0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tmo();
    err_total++;
    close_out();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // bus master: address and data offered together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aP, dP;
    awA <= a;
    wD <= d;
    awV <= 1'h1;
    wV <= 1'h1;
    aP = 1'h1;
    dP = 1'h1;
    // local flags: the valid variables only change after this time step
    for (n = 0; (aP || dP) && n < 64; n++) begin
      @(posedge clk);
      if (awR && aP) begin
        awV <= 1'h0;
        aP = 1'h0;
      end
      if (wR && dP) begin
        wV <= 1'h0;
        dP = 1'h0;
      end
    end
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (bV) break;
    end
    if (n == 64) tmo();
    r = bRsp;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    arA <= a;
    arV <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (arR) arV <= 1'h0;
      if (rV) break;
    end
    if (n == 64) tmo();
    d = rD;
    r = rRsp;
  endtask
  // bounded waits on the compressor state
  task automatic waitRun(input logic v, input int lim);
    for (int n = 0; drive.compRun !== v; n++) begin
      if (n == lim) tmo();
      @(posedge clk);
    end
  endtask
  task automatic lowFor(output int c);
    for (c = 0; drive.compRun !== 1'h1; c++) begin
      if (c == 1000) tmo();
      @(posedge clk);
    end
  endtask
  task automatic calm();
    want <= '{runCur:10'h064, peakCur:10'h064, shellT:8'sh28, pressMv:13'h0fa0,
              airT:8'sh14, disT:8'sh14, pipeT:8'sh14, hexT:8'sh14};
  endtask
  // expectation helpers; tick phase adds slack to measured delays
  function automatic logic heatExp(logic h, int a, int d);
    if (a > 7 || d > 16) return 1'h0;
    return (a < 5 && d <= 11) ? 1'h1 : h;
  endfunction
  function automatic logic inRange(int c, int s);
    return c >= (s - 2) * T && c <= (s + 2) * T + 4;
  endfunction
  // main sequence
  initial begin
    calm();
    g0 = $urandom(32'hc096);
    cyc(8);
    rst_n <= 1'h1;
    cyc(2);
    chk(drive, 32'h0);
    rd(4'hc, rdv, rsp);
    chk(rsp, RESP_SLVERR);
    rd(OFS_CTRL, rdv, rsp);
    chk(rdv, 32'h0);
    heat = 1'h0;
    for (int i = 0; i < 24; i++) begin
      g0 = $urandom_range(10, 0) - 2;
      g1 = $urandom_range(19, 8);
      want.airT <= 8'(g0);
      want.disT <= 8'(g1);
      cyc(3);
      heat = heatExp(heat, g0, g1);
      chk(drive.heaterOn, heat);
    end
    calm();
    for (int m = 0; m < 2; m++) begin
      wr(OFS_CTRL, {30'h0, m[0], 1'h1}, rsp);
      chk(rsp, RESP_OKAY);
      waitRun(1'h1, 1000);
      chk(drive.coolRegEn, 1'h0);
      g0 = m ? X_HEAT : X_COOL;
      want.runCur <= 10'(g0);
      cyc(4);
      chk(drive.freqReduce, 1'h0);
      want.runCur <= 10'(g0 + 1);
      cyc(4);
      chk(drive.freqReduce, 1'h1);
      want.runCur <= 10'(g0);
      cyc(4);
      chk(drive.freqReduce, 1'h0);
      want.airT <= 8'sh0f;
      cyc(4);
      chk(drive.curLimit, m[0]);
      want.airT <= 8'sh0e;
      cyc(4);
      chk(drive.curLimit, 1'h0);
      cyc(62 * T);
      chk(drive.coolRegEn, !m[0]);
      want.airT <= -8'sh05;
      want.pipeT <= -8'sh05;
      cyc(4);
      if (m) chk({drive.deiceOn, drive.fanStop}, 2'h3);
      panelStop <= 1'h1;
      cyc(3);
      chk(drive.compRun, 1'h0);
      wr(OFS_CTRL, 32'h0, rsp);
      panelStop <= 1'h0;
      calm();
    end
    wr(OFS_CTRL, 32'h1, rsp);
    waitRun(1'h1, 1000);
    want.hexT <= -8'sh01;
    cyc(8 * T);
    chk(drive.compRun, 1'h1);
    cyc(4 * T);
    chk(drive.compRun, 1'h0);
    want.hexT <= 8'sh02;
    lowFor(g0);
    chk(inRange(g0, 180), 1'h1);
    rd(OFS_HIST, rdv, rsp);
    chk(rdv[10:8], 3'h5);
    chk(drive.lockCode, LC_NONE);
    wr(OFS_CTRL, 32'h0, rsp);
    cyc(20 * T);
    chk(drive.compRun, 1'h1);
    cyc(14 * T);
    chk(drive.compRun, 1'h0);
    for (int k = 0; k < 4; k++) begin
      calm();
      case (k)
        0: want.runCur <= 10'h118;
        1: want.peakCur <= 10'h155;
        2: want.shellT <= 8'sh6c;
        default: want.pressMv <= 13'h0000;
      endcase
      wr(OFS_CTRL, 32'h3, rsp);
      waitRun(1'h1, 1000);
      if (k < 2) begin
        waitRun(1'h0, 100);
        lowFor(g0);
        waitRun(1'h0, 100);
        lowFor(g1);
        chk(inRange(g0, 180), 1'h1);
        chk(inRange(g1, k ? 60 : 180), 1'h1);
      end
      if (k == 3) begin
        for (g0 = 0; drive.compRun === 1'h1 && g0 < 1000; g0++) @(posedge clk);
        chk(inRange(g0, 65), 1'h1);
      end
      for (g0 = 0; drive.lockCode === LC_NONE; g0++) begin
        if (g0 == 8000) tmo();
        @(posedge clk);
      end
      cyc(2);
      chk(drive.lockCode, codes[k]);
      chk(drive.compRun, 1'h0);
      g1 = drive.lampBlink;
      cyc(T);
      chk(drive.lampBlink, !g1[0]);
      wr(OFS_CTRL, 32'h3, rsp);
      cyc(4);
      rd(OFS_STAT, rdv, rsp);
      chk(rdv[10:8], codes[k]);
      wr(OFS_CTRL, 32'h4, rsp);
      cyc(2);
      chk(drive.lockCode, LC_NONE);
    end
    // slow peak recurrence: second trip only after the quick window has passed
    calm();
    wr(OFS_CTRL, 32'h3, rsp);
    waitRun(1'h1, 1000);
    want.peakCur <= 10'h155;
    waitRun(1'h0, 100);
    calm();
    lowFor(g0);
    cyc(34 * T);
    want.peakCur <= 10'h155;
    waitRun(1'h0, 100);
    lowFor(g0);
    chk(inRange(g0, 120), 1'h1);
    close_out();
  end
endmodule
`default_nettype wire
